// file: hw/ecp_pkg.sv
// Purpose: shared constants and types for the extended-capabilities parallel port
// Assumes: 8-bit port word, one shared byte FIFO for every FIFO mode
// Notes:   offsets are relative to the configured base address
package ecp_pkg;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [15:0] OFF_DATA     = 16'h0000;
   localparam logic [15:0] OFF_STATUS   = 16'h0001;
   localparam logic [15:0] OFF_CONTROL  = 16'h0002;
   localparam logic [15:0] OFF_FIFO     = 16'h0400;
   localparam logic [15:0] OFF_CFG_B    = 16'h0401;
   localparam logic [15:0] OFF_EXT_CTRL = 16'h0402;

   // ****************************************************************
   // modes of the extended control register
   // ****************************************************************
   typedef enum logic [2:0] {
      MODE_STANDARD    = 3'b000,
      MODE_BIDIR       = 3'b001,
      MODE_COMPAT_FIFO = 3'b010,
      MODE_ECP         = 3'b011,
      MODE_EPP         = 3'b100,
      MODE_RESERVED    = 3'b101,
      MODE_TEST        = 3'b110,
      MODE_CONFIG      = 3'b111
   } port_mode_e;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int CTL_STROBE   = 0;
   localparam int CTL_AUTOFD   = 1;
   localparam int CTL_INIT     = 2;
   localparam int CTL_SELECTIN = 3;
   localparam int CTL_DIR      = 5;
   localparam int EXT_MODE_LSB = 5;
   localparam int EXT_ERR_DIS  = 2;  // position inside the 3-bit ext_ctl copy
   localparam int EXT_WR_ERR   = 4;  // same bit, position in the written byte
   localparam int RLE_ADDR_BIT = 7;

   localparam logic [7:0] DATA_RESET     = 8'h00;
   localparam logic [5:0] CONTROL_RESET  = 6'h00;
   localparam logic [2:0] EXT_CTRL_RESET = 3'h5;
   localparam logic [7:0] CFG_A_VALUE    = 8'h10;
   localparam int         FIFO_DEPTH     = 16;

   // ****************************************************************
   // link engines and read sources
   // ****************************************************************
   typedef enum logic [2:0] {
      FWD_IDLE    = 3'b000,
      FWD_LOAD    = 3'b001,
      FWD_SETUP   = 3'b010,
      FWD_STROBE  = 3'b011,
      FWD_RELEASE = 3'b100
   } fwd_state_e;

   typedef enum logic [1:0] {
      REV_IDLE   = 2'b00,
      REV_ASK    = 2'b01,
      REV_PUSH   = 2'b10,
      REV_FINISH = 2'b11
   } rev_state_e;

   typedef enum logic [2:0] {
      SRC_NONE    = 3'b000,
      SRC_PINS    = 3'b001,
      SRC_STATUS  = 3'b010,
      SRC_CONTROL = 3'b011,
      SRC_FIFO    = 3'b100,
      SRC_CFG_A   = 3'b101,
      SRC_CFG_B   = 3'b110,
      SRC_EXT     = 3'b111
   } read_src_e;

endpackage

// file: hw/ecp_fifo_mem.sv
// Purpose: storage array of the shared port FIFO
// Assumes: one write and one read address per cycle
// Notes:   read data is registered, so it trails the read address by one cycle
`timescale 1ns/1ns
module ecp_fifo_mem #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   // the array has no reset on purpose: only the output register needs one
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule // ecp_fifo_mem

// file: hw/ecp_parallel_port_core.sv
// Purpose: extended-capabilities parallel port, host register side and link engines
// Assumes: host strobes are one-cycle pulses synchronous to clk; link inputs too
// Notes:   all state outside u_fifo_mem lives in one struct; two comb processes, one register process
`timescale 1ns/1ns
module ecp_parallel_port_core #(
   parameter int FIFO_DEPTH = ecp_pkg::FIFO_DEPTH,
   parameter int FIFO_AW    = $clog2(FIFO_DEPTH)
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] base_addr,
   input  wire logic [15:0] io_addr,
   input  wire logic        aen,
   input  wire logic        io_rd,
   input  wire logic        io_wr,
   input  wire logic [7:0]  io_wdata,
   output logic      [7:0]  io_rdata,
   output logic             io_rd_valid,
   input  wire logic [7:0]  pd_in,
   output logic      [7:0]  pd_out,
   output logic             pd_oe,
   output logic             host_clock_out_n,
   output logic             host_flow_out_n,
   output logic             direction_request_out_n,
   output logic             mode_indicate_out_n,
   input  wire logic        peripheral_link_clock,
   input  wire logic        peripheral_flow_ack,
   input  wire logic        direction_change_ack_n,
   input  wire logic        peripheral_request_in_n,
   input  wire logic        select_in,
   output logic             fault_event
);

   typedef struct packed {
      logic [7:0]           data_latch;
      logic [5:0]           control;
      ecp_pkg::port_mode_e  mode;
      logic [2:0]           ext_ctl;
      logic [FIFO_AW-1:0]   head;
      logic [FIFO_AW-1:0]   tail;
      logic [FIFO_AW:0]     count;
      ecp_pkg::fwd_state_e  fwd;
      ecp_pkg::rev_state_e  rev;
      logic [7:0]           link_byte;
      logic                 strobe_n;
      logic                 host_flow_ack;
      logic [6:0]           rle;
      logic [6:0]           remain;
      logic [8:0]           rev_word;
      logic                 rd_pend;
      ecp_pkg::read_src_e   rd_sel;
      logic [7:0]           rdata;
      logic                 rd_valid;
      logic                 fault_prev;
      logic                 fault_pulse;
   } core_state_s;

   localparam core_state_s STATE_RESET = '{
      data_latch: ecp_pkg::DATA_RESET,
      control:    ecp_pkg::CONTROL_RESET,
      mode:       ecp_pkg::MODE_STANDARD,
      ext_ctl:    ecp_pkg::EXT_CTRL_RESET,
      fwd:        ecp_pkg::FWD_IDLE,
      rev:        ecp_pkg::REV_IDLE,
      rd_sel:     ecp_pkg::SRC_NONE,
      strobe_n:   1'b1,
      host_flow_ack:    1'b1,
      fault_prev: 1'b1,
      default:    '0
   };

   localparam logic [FIFO_AW:0] FIFO_FULL_COUNT = (FIFO_AW+1)'(FIFO_DEPTH);

   core_state_s        s;
   core_state_s        next_s;
   logic               push;
   logic               pop;
   logic [8:0]         push_word;
   logic [8:0]         mem_q;
   logic [FIFO_AW-1:0] mem_rd_addr;
   logic [15:0]        offset;
   logic               hit_rd;
   logic               hit_wr;
   logic               is_ecp;
   logic               is_std;
   logic               dir_in;
   logic               fifo_full;
   logic               fifo_empty;
   logic               fwd_run;
   logic               rev_run;

   // ****************************************************************
   // shared FIFO storage
   // ****************************************************************
   // an empty FIFO points the read at the last byte taken, so a read re-reads it
   assign mem_rd_addr = fifo_empty ? s.head - 1'b1 : s.head;

   ecp_fifo_mem #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo_mem (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (push),
      .wr_addr (s.tail),
      .wr_data (push_word),
      .rd_addr (mem_rd_addr),
      .rd_data (mem_q)
   );

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   assign offset     = io_addr - base_addr;
   assign hit_rd     = io_rd && !aen;
   assign hit_wr     = io_wr && !aen;
   assign is_ecp     = (s.mode == ecp_pkg::MODE_ECP);
   assign is_std     = (s.mode == ecp_pkg::MODE_STANDARD) || (s.mode == ecp_pkg::MODE_BIDIR);
   assign dir_in     = s.control[ecp_pkg::CTL_DIR];
   assign fifo_full  = (s.count == FIFO_FULL_COUNT);
   assign fifo_empty = (s.count == '0);
   // forward engine: compat FIFO always outward, ECP only once the link is forward
   assign fwd_run    = (s.mode == ecp_pkg::MODE_COMPAT_FIFO)
                       || (is_ecp && !dir_in && direction_change_ack_n);
   assign rev_run    = is_ecp && dir_in && !direction_change_ack_n;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_s             = s;
      push               = 1'b0;
      pop                = 1'b0;
      push_word          = '0;
      next_s.fault_pulse = 1'b0;
      next_s.rd_valid    = 1'b0;
      next_s.fault_prev  = peripheral_request_in_n;

      // answer a read taken one cycle earlier; FIFO data has now left the array
      if (s.rd_pend) begin
         next_s.rd_pend  = 1'b0;
         next_s.rd_valid = (s.rd_sel != ecp_pkg::SRC_NONE);
         case (s.rd_sel)
            ecp_pkg::SRC_PINS:    next_s.rdata = pd_in;
            ecp_pkg::SRC_STATUS:  next_s.rdata = {!peripheral_flow_ack, peripheral_link_clock,
                                                  direction_change_ack_n, select_in,
                                                  peripheral_request_in_n, 3'h0};
            ecp_pkg::SRC_CONTROL: next_s.rdata = {2'h0, s.control};
            ecp_pkg::SRC_FIFO:    next_s.rdata = mem_q[7:0];
            ecp_pkg::SRC_CFG_A:   next_s.rdata = ecp_pkg::CFG_A_VALUE;
            // compress reads low: no hardware compression offered
            ecp_pkg::SRC_CFG_B:   next_s.rdata = 8'h00;
            ecp_pkg::SRC_EXT:     next_s.rdata = {s.mode, s.ext_ctl,
                                                  fifo_full, fifo_empty};
            default:              next_s.rdata = 8'h00;
         endcase
      end

      // host reads
      if (hit_rd) begin
         next_s.rd_pend = 1'b1;
         next_s.rd_sel  = ecp_pkg::SRC_NONE;
         case (offset)
            ecp_pkg::OFF_DATA:     next_s.rd_sel = ecp_pkg::SRC_PINS;
            ecp_pkg::OFF_STATUS:   next_s.rd_sel = ecp_pkg::SRC_STATUS;
            ecp_pkg::OFF_CONTROL:  next_s.rd_sel = ecp_pkg::SRC_CONTROL;
            ecp_pkg::OFF_FIFO: begin
               if (s.mode == ecp_pkg::MODE_CONFIG) begin
                  next_s.rd_sel = ecp_pkg::SRC_CFG_A;
               end else if (s.mode == ecp_pkg::MODE_TEST || (is_ecp && dir_in)) begin
                  next_s.rd_sel = ecp_pkg::SRC_FIFO;
                  pop           = !fifo_empty;
               end
            end
            ecp_pkg::OFF_CFG_B: begin
               if (s.mode == ecp_pkg::MODE_CONFIG) begin
                  next_s.rd_sel = ecp_pkg::SRC_CFG_B;
               end
            end
            ecp_pkg::OFF_EXT_CTRL: next_s.rd_sel = ecp_pkg::SRC_EXT;
            default:               next_s.rd_sel = ecp_pkg::SRC_NONE;
         endcase
      end

      // host writes; a write into a full FIFO is dropped
      if (hit_wr) begin
         case (offset)
            ecp_pkg::OFF_DATA: begin
               if (is_std) begin
                  next_s.data_latch = io_wdata;
               end else if (is_ecp && !dir_in && !fifo_full) begin
                  push      = 1'b1;
                  push_word = {1'b1, io_wdata};
               end
            end
            ecp_pkg::OFF_CONTROL: next_s.control = io_wdata[5:0];
            ecp_pkg::OFF_FIFO: begin
               if ((s.mode == ecp_pkg::MODE_COMPAT_FIFO || (is_ecp && !dir_in)
                    || s.mode == ecp_pkg::MODE_TEST) && !fifo_full) begin
                  push      = 1'b1;
                  push_word = {1'b0, io_wdata};
               end
            end
            ecp_pkg::OFF_EXT_CTRL: begin
               next_s.mode    = ecp_pkg::port_mode_e'(io_wdata[7:ecp_pkg::EXT_MODE_LSB]);
               next_s.ext_ctl = io_wdata[4:2];
               // enabling the error event while the request is already low still fires
               if (is_ecp && s.ext_ctl[ecp_pkg::EXT_ERR_DIS]
                   && !io_wdata[ecp_pkg::EXT_WR_ERR] && !peripheral_request_in_n) begin
                  next_s.fault_pulse = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // ****************************************************************
      // forward engine
      // ****************************************************************
      unique case (s.fwd)
         ecp_pkg::FWD_IDLE: begin
            next_s.strobe_n = 1'b1;
            if (fwd_run && !fifo_empty && !peripheral_flow_ack) begin
               pop        = 1'b1;
               next_s.fwd = ecp_pkg::FWD_LOAD;
            end
         end
         ecp_pkg::FWD_LOAD: begin
            next_s.link_byte = mem_q[7:0];
            // host ack high marks data, low marks an address/run-length byte
            if (is_ecp) begin
               next_s.host_flow_ack = !mem_q[8];
            end
            next_s.fwd = ecp_pkg::FWD_SETUP;
         end
         ecp_pkg::FWD_SETUP: begin
            next_s.strobe_n = 1'b0;
            next_s.fwd      = ecp_pkg::FWD_STROBE;
         end
         ecp_pkg::FWD_STROBE: begin
            if (peripheral_flow_ack) begin
               next_s.strobe_n = 1'b1;
               next_s.fwd      = ecp_pkg::FWD_RELEASE;
            end
         end
         ecp_pkg::FWD_RELEASE: begin
            if (!peripheral_flow_ack) begin
               next_s.fwd = ecp_pkg::FWD_IDLE;
            end
         end
         default: next_s.fwd = ecp_pkg::FWD_IDLE;
      endcase

      // ****************************************************************
      // reverse engine with run-length expansion
      // ****************************************************************
      unique case (s.rev)
         ecp_pkg::REV_IDLE: begin
            if (rev_run) begin
               next_s.host_flow_ack = 1'b0;
               next_s.rev     = ecp_pkg::REV_ASK;
            end
         end
         ecp_pkg::REV_ASK: begin
            if (!peripheral_link_clock) begin
               if (!peripheral_flow_ack && !pd_in[ecp_pkg::RLE_ADDR_BIT]) begin
                  next_s.rle     = pd_in[6:0];
                  next_s.host_flow_ack = 1'b1;
                  next_s.rev     = ecp_pkg::REV_FINISH;
               end else begin
                  next_s.rev_word = {!peripheral_flow_ack, pd_in};
                  next_s.remain   = peripheral_flow_ack ? s.rle : 7'h00;
                  next_s.rle      = peripheral_flow_ack ? 7'h00 : s.rle;
                  next_s.rev      = ecp_pkg::REV_PUSH;
               end
            end
         end
         ecp_pkg::REV_PUSH: begin
            // a full FIFO holds host ack low, which stalls the peripheral
            if (!fifo_full) begin
               push      = 1'b1;
               push_word = s.rev_word;
               if (s.remain == 7'h00) begin
                  next_s.host_flow_ack = 1'b1;
                  next_s.rev     = ecp_pkg::REV_FINISH;
               end else begin
                  next_s.remain = s.remain - 7'h01;
               end
            end
         end
         ecp_pkg::REV_FINISH: begin
            if (peripheral_link_clock) begin
               next_s.rev = ecp_pkg::REV_IDLE;
            end
         end
      endcase

      // error event on the falling edge of the peripheral request, ECP mode only
      if (is_ecp && !s.ext_ctl[ecp_pkg::EXT_ERR_DIS]
          && s.fault_prev && !peripheral_request_in_n) begin
         next_s.fault_pulse = 1'b1;
      end

      // ****************************************************************
      // FIFO pointers
      // ****************************************************************
      if (push) begin
         next_s.tail = s.tail + 1'b1;
      end
      if (pop) begin
         next_s.head = s.head + 1'b1;
      end
      if (push && !pop) begin
         next_s.count = s.count + 1'b1;
      end else if (pop && !push) begin
         next_s.count = s.count - 1'b1;
      end

      // writing standard or bidirectional mode discards anything queued and parks the engines
      if (hit_wr && offset == ecp_pkg::OFF_EXT_CTRL
          && (io_wdata[7:5] == ecp_pkg::MODE_STANDARD || io_wdata[7:5] == ecp_pkg::MODE_BIDIR)) begin
         next_s.head     = '0;
         next_s.tail     = '0;
         next_s.count    = '0;
         next_s.fwd      = ecp_pkg::FWD_IDLE;
         next_s.rev      = ecp_pkg::REV_IDLE;
         next_s.strobe_n = 1'b1;
         next_s.host_flow_ack  = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // pins and answers
   // ****************************************************************
   assign io_rdata                = s.rdata;
   assign io_rd_valid             = s.rd_valid;
   assign fault_event             = s.fault_pulse;
   assign pd_out                  = is_std ? s.data_latch : s.link_byte;
   assign host_clock_out_n        = is_std ? !s.control[ecp_pkg::CTL_STROBE] : s.strobe_n;
   assign host_flow_out_n         = is_ecp ? s.host_flow_ack : !s.control[ecp_pkg::CTL_AUTOFD];
   assign direction_request_out_n = is_ecp ? !dir_in : s.control[ecp_pkg::CTL_INIT];
   assign mode_indicate_out_n     = is_ecp ? 1'b1 : !s.control[ecp_pkg::CTL_SELECTIN];

   always_comb begin
      case (s.mode)
         ecp_pkg::MODE_STANDARD,
         ecp_pkg::MODE_COMPAT_FIFO: pd_oe = 1'b1;
         ecp_pkg::MODE_ECP:         pd_oe = !dir_in && direction_change_ack_n;
         default:                   pd_oe = !dir_in;
      endcase
   end

endmodule // ecp_parallel_port_core

// file: tb/ecp_sva.sv
// Purpose: port-level checks of the parallel port core
// Assumes: one clock, rst asynchronous and active high
// Notes:   bound to every core instance
`timescale 1ns/1ns
module ecp_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic aen,
   input wire logic io_rd,
   input wire logic io_rd_valid,
   input wire logic host_clock_out_n,
   input wire logic host_flow_out_n,
   input wire logic peripheral_flow_ack,
   input wire logic peripheral_link_clock,
   input wire logic direction_change_ack_n,
   input wire logic peripheral_request_in_n,
   input wire logic fault_event
);
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_read_answer: assert property (io_rd_valid |-> $past(io_rd, 2) && !$past(aen, 2))
      else $error("read answer without qualified request");
   a_dma_ignored: assert property (io_rd && aen |-> ##2 !io_rd_valid)
      else $error("read answered during address enable high");
   a_strobe_hold: assert property (!host_clock_out_n && !peripheral_flow_ack |=> !host_clock_out_n)
      else $error("strobe released before busy");
   a_strobe_release: assert property ($rose(host_clock_out_n) |-> $past(peripheral_flow_ack))
      else $error("strobe rose without busy");
   a_fault_cause: assert property (fault_event |-> !$past(peripheral_request_in_n))
      else $error("fault event without request low");
   a_fault_pulse: assert property (fault_event |=> !fault_event)
      else $error("fault event longer than one cycle");
   a_ack_request: assert property ($fell(host_flow_out_n) && !direction_change_ack_n
      |-> $past(peripheral_link_clock)) else $error("host ack fell with clock low");
   a_ack_valid: assert property ($rose(host_flow_out_n) && !direction_change_ack_n
      |-> !$past(peripheral_link_clock)) else $error("host ack rose without data");
endmodule // ecp_sva
bind ecp_parallel_port_core ecp_sva u_sva (.*);

// file: tb/ecp_periph_model.sv
// Purpose: behavioural peripheral on the far side of the link
// Assumes: acts at the falling edge, away from the core's sampling edge
// Notes:   reverse entries are {busy, byte}; released data lines show the inverse
`timescale 1ns/1ns
module ecp_periph_model (
   input  wire logic       clk,
   input  wire logic       host_clock_out_n,
   input  wire logic       host_flow_out_n,
   input  wire logic       direction_request_out_n,
   input  wire logic [7:0] pd_out,
   input  wire logic       rev_en,
   output logic            peripheral_link_clock,
   output logic            peripheral_flow_ack,
   output logic            direction_change_ack_n,
   output logic      [7:0] pd_in
);
   // ****************************************************************
   // link handshakes
   // ****************************************************************
   logic [8:0] fwd_q[$];
   logic [8:0] rev_q[$];
   initial begin
      {peripheral_link_clock, peripheral_flow_ack, direction_change_ack_n} = 3'h5;
      pd_in = 8'h00;
   end
   always @(negedge clk) begin
      direction_change_ack_n = ~(rev_en & ~direction_request_out_n);
      if (direction_change_ack_n) begin
         if (!host_clock_out_n && !peripheral_flow_ack) begin
            fwd_q.push_back({host_flow_out_n, pd_out});
            peripheral_flow_ack = 1'b1;
         end else if (host_clock_out_n) begin
            peripheral_flow_ack = 1'b0;
         end
      end else if (!host_flow_out_n && peripheral_link_clock && rev_q.size() > 0) begin
         {peripheral_flow_ack, pd_in} = rev_q.pop_front();
         peripheral_link_clock = 1'b0;
      end else if (host_flow_out_n && !peripheral_link_clock) begin
         peripheral_link_clock = 1'b1;
         pd_in = ~pd_in;
      end
   end
endmodule // ecp_periph_model

// file: tb/testbench.sv
// Purpose: self-checking bench of the parallel port core
// Assumes: inputs change at the falling edge
// Notes:   expected bytes follow the mode table and fifo order
`timescale 1ns/1ns
module testbench;
   logic        clk, rst, aen, io_rd, io_wr, io_rd_valid, pd_oe, fault_event, rev_en;
   logic        host_clock_out_n, host_flow_out_n, direction_request_out_n, select_in;
   logic        mode_indicate_out_n, peripheral_link_clock, peripheral_flow_ack;
   logic        direction_change_ack_n, peripheral_request_in_n;
   logic [15:0] base_addr, io_addr;
   logic [7:0]  io_wdata, io_rdata, pd_in, pd_out;
   int          miscompares, n_checks, cycles, n_fault;
   ecp_parallel_port_core dut (.*);
   ecp_periph_model m (.*);
   // ****************************************************************
   // clock, watchdog, tasks
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (fault_event === 1'b1) n_fault++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [15:0] off, logic [7:0] d);
      {io_addr, io_wdata, io_wr} = {base_addr + off, d, 1'b1};
      @(negedge clk);
      io_wr = 1'b0;
      @(negedge clk);
   endtask
   // exp[8] low means no answer is expected
   task automatic rd(logic [15:0] off, logic [8:0] exp);
      {io_addr, io_rd} = {base_addr + off, 1'b1};
      @(negedge clk);
      io_rd = 1'b0;
      // the answer stands for one cycle only, from the first edge after the taking edge
      @(negedge clk);
      if (exp[8]) chk($sformatf("reg %h", off), exp, {io_rd_valid, io_rdata});
      else chk("no answer", 9'h000, {8'h00, io_rd_valid});
   endtask
   task automatic wait_fwd(int n);
      for (int i = 0; i < 300 && m.fwd_q.size() < n; i++) @(negedge clk);
   endtask
   initial begin
      {rst, aen, io_rd, io_wr, rev_en, select_in, peripheral_request_in_n} = 7'h43;
      {base_addr, io_addr, io_wdata} = 40'h0378_0000_00;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      rd(ecp_pkg::OFF_EXT_CTRL, 9'h115);
      rd(16'h0403, 9'h000);
      wr(ecp_pkg::OFF_DATA, 8'ha5);
      chk("data pins", 9'h0a5, {1'b0, pd_out});
      rd(ecp_pkg::OFF_DATA, 9'h100);
      rd(ecp_pkg::OFF_STATUS, 9'h1f8);
      for (int i = 0; i < 8; i++) begin
         wr(ecp_pkg::OFF_EXT_CTRL, {i[2:0], 5'h14});
         rd(ecp_pkg::OFF_EXT_CTRL, {1'b1, i[2:0], 5'h15});
         if (i == 3) chk("mode indicate", 9'h001, {8'h00, mode_indicate_out_n});
      end
      rd(ecp_pkg::OFF_FIFO, 9'h110);
      rd(ecp_pkg::OFF_CFG_B, 9'h100);
      aen = 1'b1;
      rd(ecp_pkg::OFF_CFG_B, 9'h000);
      aen = 1'b0;
      wr(ecp_pkg::OFF_EXT_CTRL, 8'hd4);
      for (int i = 0; i <= 16; i++) wr(ecp_pkg::OFF_FIFO, 8'(i * 8'h11));
      rd(ecp_pkg::OFF_EXT_CTRL, 9'h1d6);
      for (int i = 0; i < 16; i++) rd(ecp_pkg::OFF_FIFO, {1'b1, 8'(i * 8'h11)});
      rd(ecp_pkg::OFF_FIFO, 9'h1ff);
      wr(ecp_pkg::OFF_EXT_CTRL, 8'h54);
      wr(ecp_pkg::OFF_FIFO, 8'h81);
      wr(ecp_pkg::OFF_FIFO, 8'h7e);
      wait_fwd(2);
      chk("compat byte", 9'h181, m.fwd_q[0]);
      chk("compat byte", 9'h17e, m.fwd_q[1]);
      wr(ecp_pkg::OFF_EXT_CTRL, 8'h74);
      wr(ecp_pkg::OFF_DATA, 8'h05);
      wr(ecp_pkg::OFF_FIFO, 8'hc3);
      wait_fwd(4);
      chk("address byte", 9'h005, m.fwd_q[2]);
      chk("data byte", 9'h1c3, m.fwd_q[3]);
      wr(ecp_pkg::OFF_EXT_CTRL, 8'h60);
      peripheral_request_in_n = 1'b0;
      // re-enabling the event while the request is still low must fire once more
      wr(ecp_pkg::OFF_EXT_CTRL, 8'h70);
      wr(ecp_pkg::OFF_EXT_CTRL, 8'h60);
      peripheral_request_in_n = 1'b1;
      chk("fault events", 9'h002, 9'(n_fault));
      wr(ecp_pkg::OFF_CONTROL, 8'h20);
      rd(ecp_pkg::OFF_CONTROL, 9'h120);
      rev_en = 1'b1;
      m.rev_q = '{9'h002, 9'h13c, 9'h111};
      for (int i = 0; i < 500 && (m.rev_q.size() > 0 || !peripheral_link_clock); i++)
         @(negedge clk);
      chk("drive enable", 9'h000, {8'h00, pd_oe});
      chk("direction", 9'h000, {8'h00, direction_request_out_n});
      for (int i = 0; i < 4; i++) rd(ecp_pkg::OFF_FIFO, {1'b1, i < 3 ? 8'h3c : 8'h11});
      rd(ecp_pkg::OFF_EXT_CTRL, 9'h161);
      give_verdict();
   end
endmodule // testbench
